// *** hw/afbm_pkg.sv ***
`default_nettype none
package afbm_pkg;
  // task-file offsets
  localparam logic [11:0] OFS_FEAT_ERR = 12'h1f1;
  localparam logic [11:0] OFS_SECCNT   = 12'h1f2;
  localparam logic [11:0] OFS_SECNUM   = 12'h1f3;
  localparam logic [11:0] OFS_CYL_LO   = 12'h1f4;
  localparam logic [11:0] OFS_CYL_HI   = 12'h1f5;
  localparam logic [11:0] OFS_DRV_HEAD = 12'h1f6;
  localparam logic [11:0] OFS_CMD_STAT = 12'h1f7;
  // opcodes and subcommands
  localparam logic [7:0] OP_SET_FEAT  = 8'hef;
  localparam logic [7:0] OP_SET_MULT  = 8'hc6;
  localparam logic [7:0] SUB_XFER     = 8'h03;
  localparam logic [7:0] SUB_AAM_ON   = 8'h42;
  localparam logic [7:0] SUB_AAM_OFF  = 8'hc2;
  // transfer type and mode fields of the sector count
  localparam int          XT_MSB      = 7;
  localparam int          XT_LSB      = 3;
  localparam int          XM_MSB      = 2;
  localparam logic [4:0]  XT_PIO_DEF  = 5'h00;
  localparam logic [4:0]  XT_PIO_FC   = 5'h01;
  localparam logic [4:0]  XT_MDMA     = 5'h04;
  localparam logic [4:0]  XT_UDMA     = 5'h08;
  localparam logic [2:0]  XM_PIO_MAX  = 3'h4;
  localparam logic [2:0]  XM_MDMA_MAX = 3'h2;
  localparam logic [2:0]  XM_UDMA_MAX = 3'h5;
  localparam logic [7:0]  XFER_RST    = 8'h00;
  // acoustic levels
  localparam logic [7:0] AAM_RSVD    = 8'hff;
  localparam logic [7:0] AAM_PERF_LO = 8'hc0;
  localparam logic [7:0] AAM_QUIET_LO = 8'h80;
  localparam logic [7:0] AAM_VEND    = 8'h00;
  // status and error bits
  localparam int STAT_BSY  = 7;
  localparam int STAT_DRDY = 6;
  localparam int STAT_ERR  = 0;
  localparam int ERR_ABRT  = 2;
  localparam int DH_UNIT   = 4;
  // identification words
  localparam logic [15:0] ID_W47     = 16'h8010;
  localparam logic [15:0] ID_W59_OFF = 16'h0000;
  localparam logic [7:0]  ID_W59_HI  = 8'h01;

  typedef enum logic [1:0] {
    AFBM_AAM_VENDOR  = 2'h0,
    AFBM_AAM_RETIRED = 2'h1,
    AFBM_AAM_QUIET   = 2'h2,
    AFBM_AAM_PERF    = 2'h3
  } afbm_aam_e;

  typedef enum logic [2:0] {
    AFBM_IDLE = 3'b001,
    AFBM_EXEC = 3'b010,
    AFBM_DONE = 3'b100
  } afbm_state_e;

  typedef struct packed {
    logic [15:0] w47;
    logic [15:0] w59;
    logic        w86_b9;
    logic [7:0]  w94_lo;
  } afbm_ident_s;

  typedef struct packed {
    logic       en;
    logic [7:0] level;
  } afbm_aam_s;
endpackage : afbm_pkg
`default_nettype wire

// *** hw/afbm_top.sv ***
// Notes on behaviour
// - transfer code: upper five type, lower three mode
// - PIO 4 and MDMA 2 usable without setup
// - unsupported transfer code aborts the command
// - code 00h selects default PIO
// - codes 08h-0Ch are PIO flow-control modes
// - codes 20h-22h are multiword DMA modes
// - codes 40h-45h are Ultra DMA modes
// - subcommand 42h enables acoustic management at level
// - decode acoustic level into its classes
// - acoustic state survives every kind of reset
// - subcommand C2h disables acoustics, clears identify bits
// - opcode C6h sets block count from sector count
// - only 2, 4, 8, 16 sectors per block
// - valid count stored, multiple commands enabled
// - invalid count aborts and disables multiple mode
// - count zero disables multiple mode
// - block-count completion clears busy, raises interrupt
// - power-on or hardware reset disables multiple mode
// - software reset keeps multiple mode and count
// - identify word 47 reads 8010h
// - word 59 is 0000h or 01h with count
// - feature command: busy, save, complete with interrupt
// - opcode EFh with subcommand in features register
`default_nettype none
module afbm_top
  import afbm_pkg::*;
#(
  parameter bit UNIT_ID = 1'b0  // which drive_unit this device answers as
) (
  input  wire logic        clk_sys_i,      // 200 MHz device clock
  input  wire logic        sys_rst_i,      // power-on reset, async, high
  input  wire logic        hw_rst_n_i,     // host hardware reset pin, low
  input  wire logic        sw_rst_i,       // host software reset pin, high
  input  wire logic [11:0] hst_addr_i,     // task-file address pins
  input  wire logic        hst_wr_i,       // host write strobe pin
  input  wire logic        hst_rd_i,       // host read strobe pin
  input  wire logic [7:0]  hst_wdata_i,    // host write data pins
  input  wire afbm_aam_s   aam_nv_i,       // saved acoustic state to restore
  output logic [7:0]       hst_rdata_o,    // task-file read data
  output logic             hst_irq_o,      // interrupt request to host
  output logic             mult_en_o,      // multiple commands enabled
  output logic [7:0]       mult_cnt_o,     // sectors per block
  output logic [7:0]       xfer_code_o,    // selected transfer code
  output afbm_aam_s        aam_o,          // acoustic state, to save
  output afbm_aam_e        aam_class_o,    // decoded acoustic class
  output afbm_ident_s      ident_o         // live identify words
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers
  function automatic logic xfer_ok(input logic [7:0] c);
    logic [4:0] t;
    logic [2:0] m;
    t = c[XT_MSB:XT_LSB];
    m = c[XM_MSB:0];
    case (t)
      XT_PIO_DEF: xfer_ok = (m == 3'h0);
      XT_PIO_FC:  xfer_ok = (m <= XM_PIO_MAX);
      XT_MDMA:    xfer_ok = (m <= XM_MDMA_MAX);
      XT_UDMA:    xfer_ok = (m <= XM_UDMA_MAX);
      default:    xfer_ok = 1'b0;
    endcase
  endfunction : xfer_ok
  function automatic afbm_aam_e aam_class(input logic [7:0] l);
    if (l >= AAM_PERF_LO) begin
      aam_class = AFBM_AAM_PERF;
    end else if (l >= AAM_QUIET_LO) begin
      aam_class = AFBM_AAM_QUIET;
    end else if (l == AAM_VEND) begin
      aam_class = AFBM_AAM_VENDOR;
    end else begin
      aam_class = AFBM_AAM_RETIRED;
    end
  endfunction : aam_class
  // other listed subcommands are accepted without effect here
  function automatic logic feat_other(input logic [7:0] f);
    case (f)
      8'h02, 8'h04, 8'h05, 8'h33, 8'h54, 8'h55, 8'h66, 8'h77, 8'h81,
      8'h82, 8'h84, 8'h85, 8'h88, 8'h89, 8'haa, 8'hab, 8'hbb, 8'hcc:
        feat_other = 1'b1;
      default: feat_other = 1'b0;
    endcase
  endfunction : feat_other

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [23:0] pin_s1_q;
  logic [23:0] pin_s2_q;
  logic        wr_s3_q;
  logic        rd_s3_q;
  logic [11:0] addr_s;
  logic [7:0]  wdata_s;
  logic        wr_s;
  logic        rd_s;
  logic        hwr_s;
  logic        swr_s;
  logic        wr_pulse;
  logic        rd_pulse;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
    end else begin
      pin_s1_q <= {hst_addr_i, hst_wdata_i, hst_wr_i, hst_rd_i, ~hw_rst_n_i, sw_rst_i};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign {addr_s, wdata_s, wr_s, rd_s, hwr_s, swr_s} = pin_s2_q;
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wr_s3_q <= 1'b0;
      rd_s3_q <= 1'b0;
    end else begin
      wr_s3_q <= wr_s;
      rd_s3_q <= rd_s;
    end
  end

  assign wr_pulse = wr_s & ~wr_s3_q;
  assign rd_pulse = rd_s & ~rd_s3_q;
  ////////////////////////////////////////////////////////////////////////////
  // task file
  afbm_state_e state_q;
  logic [7:0]  feat_q;
  logic [7:0]  seccnt_q;
  logic [7:0]  secnum_q;
  logic [7:0]  cyllo_q;
  logic [7:0]  cylhi_q;
  logic [7:0]  dh_q;
  logic [7:0]  cmd_q;
  logic        err_q;
  logic        abrt_q;
  logic        busy;
  logic        cmd_go;
  logic        tf_wr;
  assign busy   = (state_q != AFBM_IDLE);
  assign tf_wr  = wr_pulse & ~busy;
  // commands for the other drive_unit are ignored
  assign cmd_go = tf_wr & (addr_s == OFS_CMD_STAT) & (dh_q[DH_UNIT] == UNIT_ID);
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      feat_q   <= 8'h00;
      seccnt_q <= 8'h00;
      secnum_q <= 8'h00;
      cyllo_q  <= 8'h00;
      cylhi_q  <= 8'h00;
      dh_q     <= 8'h00;
      cmd_q    <= 8'h00;
    end else if (tf_wr) begin
      case (addr_s)
        OFS_FEAT_ERR: feat_q   <= wdata_s;
        OFS_SECCNT:   seccnt_q <= wdata_s;
        OFS_SECNUM:   secnum_q <= wdata_s;
        OFS_CYL_LO:   cyllo_q  <= wdata_s;
        OFS_CYL_HI:   cylhi_q  <= wdata_s;
        OFS_DRV_HEAD: dh_q     <= wdata_s;
        OFS_CMD_STAT: cmd_q    <= wdata_s;
        default:      cmd_q    <= cmd_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command execution
  logic abort_now;
  logic mult_ok;
  assign mult_ok = (seccnt_q == 8'h02) | (seccnt_q == 8'h04) |
                   (seccnt_q == 8'h08) | (seccnt_q == 8'h10);
  always_comb begin
    abort_now = 1'b1;
    if (cmd_q == OP_SET_FEAT) begin
      case (feat_q)
        SUB_XFER:    abort_now = ~xfer_ok(seccnt_q);
        SUB_AAM_ON:  abort_now = (seccnt_q == AAM_RSVD);
        SUB_AAM_OFF: abort_now = 1'b0;
        default:     abort_now = ~feat_other(feat_q);
      endcase
    end else if (cmd_q == OP_SET_MULT) begin
      abort_now = ~mult_ok & (seccnt_q != 8'h00);
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q <= AFBM_IDLE;
    end else if (hwr_s | swr_s) begin
      state_q <= AFBM_IDLE;
    end else begin
      case (state_q)
        AFBM_IDLE: state_q <= cmd_go ? AFBM_EXEC : AFBM_IDLE;
        AFBM_EXEC: state_q <= AFBM_DONE;
        AFBM_DONE: state_q <= AFBM_IDLE;
        default:   state_q <= AFBM_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      err_q  <= 1'b0;
      abrt_q <= 1'b0;
    end else if (hwr_s | swr_s | cmd_go) begin
      err_q  <= 1'b0;
      abrt_q <= 1'b0;
    end else if (state_q == AFBM_EXEC) begin
      err_q  <= abort_now;
      abrt_q <= abort_now;
    end
  end
  // interrupt at completion; completion wins over a status read
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hst_irq_o <= 1'b0;
    end else if (state_q == AFBM_DONE) begin
      hst_irq_o <= 1'b1;
    end else if ((rd_pulse & (addr_s == OFS_CMD_STAT)) | cmd_go | hwr_s | swr_s) begin
      hst_irq_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // transfer mode
  // reset code leaves PIO 4 and MDMA 2 usable regardless
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      xfer_code_o <= XFER_RST;
    end else if (hwr_s) begin
      xfer_code_o <= XFER_RST;
    // type and mode fields checked as a whole code
    end else if (state_q == AFBM_EXEC && cmd_q == OP_SET_FEAT
                 && feat_q == SUB_XFER && !abort_now) begin
      xfer_code_o <= seccnt_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // acoustic management
  logic aam_load_q;
  // restore saved state on the first edge after power-on release
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aam_load_q <= 1'b1;
    end else begin
      aam_load_q <= 1'b0;
    end
  end

  // untouched by hardware and software reset
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aam_o <= '0;
    end else if (aam_load_q) begin
      aam_o <= aam_nv_i;
    end else if (state_q == AFBM_EXEC && cmd_q == OP_SET_FEAT && !abort_now) begin
      if (feat_q == SUB_AAM_ON) begin
        aam_o <= '{en: 1'b1, level: seccnt_q};
      end else if (feat_q == SUB_AAM_OFF) begin
        aam_o.en <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aam_class_o <= AFBM_AAM_VENDOR;
    end else begin
      aam_class_o <= aam_class(aam_o.level);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // multiple mode
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      mult_en_o  <= 1'b0;
      mult_cnt_o <= 8'h00;
    end else if (hwr_s) begin
      mult_en_o  <= 1'b0;
      mult_cnt_o <= 8'h00;
    end else if (state_q == AFBM_EXEC && cmd_q == OP_SET_MULT && !swr_s) begin
      if (mult_ok) begin
        mult_en_o  <= 1'b1;
        mult_cnt_o <= seccnt_q;
      end else begin
        mult_en_o  <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // identify words and read data
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ident_o <= '{w47: ID_W47, w59: ID_W59_OFF, w86_b9: 1'b0, w94_lo: 8'h00};
    end else begin
      ident_o.w47    <= ID_W47;
      ident_o.w59    <= mult_en_o ? {ID_W59_HI, mult_cnt_o} : ID_W59_OFF;
      ident_o.w86_b9 <= aam_o.en;
      ident_o.w94_lo <= aam_o.en ? aam_o.level : 8'h00;
    end
  end

  logic [7:0] status;
  always_comb begin
    status            = 8'h00;
    status[STAT_BSY]  = busy;
    status[STAT_DRDY] = ~busy;
    status[STAT_ERR]  = err_q;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hst_rdata_o <= 8'h00;
    end else begin
      case (addr_s)
        OFS_FEAT_ERR: hst_rdata_o <= {5'h00, abrt_q, 2'h0};
        OFS_SECCNT:   hst_rdata_o <= seccnt_q;
        OFS_SECNUM:   hst_rdata_o <= secnum_q;
        OFS_CYL_LO:   hst_rdata_o <= cyllo_q;
        OFS_CYL_HI:   hst_rdata_o <= cylhi_q;
        OFS_DRV_HEAD: hst_rdata_o <= dh_q;
        OFS_CMD_STAT: hst_rdata_o <= status;
        default:      hst_rdata_o <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // count stored
  mult_store_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_q == AFBM_EXEC && cmd_q == OP_SET_MULT && mult_ok && !hwr_s && !swr_s)
    |=> (mult_en_o && mult_cnt_o == $past(seccnt_q)))
    else $error("valid block count not stored");
  mult_abort_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_q == AFBM_EXEC && cmd_q == OP_SET_MULT && !mult_ok && seccnt_q != 8'h00
     && !hwr_s && !swr_s) |=> (!mult_en_o && err_q && abrt_q))
    else $error("bad block count not aborted");
  mult_zero_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_q == AFBM_EXEC && cmd_q == OP_SET_MULT && seccnt_q == 8'h00
     && !hwr_s && !swr_s) |=> (!mult_en_o && !err_q))
    else $error("zero count handled wrongly");
  done_irq_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (cmd_go && !hwr_s && !swr_s) ##1 (!hwr_s && !swr_s)[*2] |=> (hst_irq_o && !busy))
    else $error("completion interrupt missing");
  xfer_bad_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_q == AFBM_EXEC && cmd_q == OP_SET_FEAT && feat_q == SUB_XFER
     && !xfer_ok(seccnt_q) && !hwr_s && !swr_s)
    |=> (err_q && $stable(xfer_code_o)))
    else $error("bad transfer code accepted");
  aam_enable_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (state_q == AFBM_EXEC && cmd_q == OP_SET_FEAT && feat_q == SUB_AAM_ON
     && seccnt_q != AAM_RSVD && !aam_load_q) |=> ##1 (ident_o.w86_b9
     && ident_o.w94_lo == $past(seccnt_q, 2)))
    else $error("acoustic enable not reflected");
  swrst_keep_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    (swr_s && !hwr_s) |=> ($stable(mult_en_o) && $stable(mult_cnt_o)))
    else $error("software reset changed multiple mode");
  word59_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ident_o.w59 == ($past(mult_en_o) ? {ID_W59_HI, $past(mult_cnt_o)} : ID_W59_OFF))
    else $error("identify word 59 wrong");
  word47_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
    ident_o.w47 == ID_W47)
    else $error("identify word 47 wrong");
endmodule : afbm_top
`default_nettype wire

// *** test/afbm_host_model.sv ***
`default_nettype none
module afbm_host_model
  import afbm_pkg::*;
(
  input  wire logic       clk_sys_i,  // device clock
  input  wire logic [7:0] rdata_i,    // task-file read data
  output logic [11:0]     addr_o,     // task-file address
  output logic            wr_o,       // write strobe
  output logic            rd_o,       // read strobe
  output logic [7:0]      wdata_o,    // write data
  output logic [7:0]      rd_val_o,   // last byte read
  output logic            rd_tick_o   // toggles per finished read
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    addr_o    = OFS_CMD_STAT;
    wr_o      = 1'b0;
    rd_o      = 1'b0;
    wdata_o   = 8'h00;
    rd_val_o  = 8'h00;
    rd_tick_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys_i) #1;
    addr_o  = a;
    wdata_o = d;
    @(posedge clk_sys_i) #1;
    wr_o = 1'b1;
    repeat (5) @(posedge clk_sys_i);
    #1 wr_o = 1'b0;
    @(posedge clk_sys_i) #1;
    // released lines show the inverse of the last byte
    wdata_o = ~d;
    repeat (2) @(posedge clk_sys_i);
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk_sys_i) #1;
    addr_o = a;
    rd_o   = 1'b1;
    repeat (5) @(posedge clk_sys_i);
    #1 rd_val_o = rdata_i;
    rd_o      = 1'b0;
    rd_tick_o = ~rd_tick_o;
    repeat (2) @(posedge clk_sys_i);
  endtask : rd
  task automatic cmd(input logic [7:0] f, input logic [7:0] sc, input logic [7:0] dh,
                     input logic [7:0] op);
    wr(OFS_FEAT_ERR, f);
    wr(OFS_SECCNT, sc);
    wr(OFS_DRV_HEAD, dh);
    wr(OFS_CMD_STAT, op);
  endtask : cmd
endmodule : afbm_host_model
`default_nettype wire

// *** test/ata_feature_and_block_mode_setup_test.sv ***
`default_nettype none
module ata_feature_and_block_mode_setup_test
  import afbm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys_i, sys_rst_i, hw_rst_n_i, sw_rst_i, hst_wr_i, hst_rd_i;
  logic [11:0] hst_addr_i;
  logic [7:0]  hst_wdata_i, hst_rdata_o, mult_cnt_o, xfer_code_o, host_val, lv, c;
  logic        hst_irq_o, mult_en_o, host_tick, m_en, ok;
  afbm_aam_s   aam_nv_i, aam_o, m_aam;
  afbm_aam_e   aam_class_o;
  afbm_ident_s ident_o;
  logic [7:0]  m_cnt, m_xfer;
  logic [79:0] exp_q[$];
  string       nam_q[$];
  int          failures, compares, seed, i;
  afbm_top DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .hw_rst_n_i(hw_rst_n_i),
    .sw_rst_i(sw_rst_i), .hst_addr_i(hst_addr_i), .hst_wr_i(hst_wr_i), .hst_rd_i(hst_rd_i),
    .hst_wdata_i(hst_wdata_i), .aam_nv_i(aam_nv_i), .hst_rdata_o(hst_rdata_o),
    .hst_irq_o(hst_irq_o), .mult_en_o(mult_en_o), .mult_cnt_o(mult_cnt_o),
    .xfer_code_o(xfer_code_o), .aam_o(aam_o), .aam_class_o(aam_class_o), .ident_o(ident_o));
  afbm_host_model u_host (.clk_sys_i(clk_sys_i), .rdata_i(hst_rdata_o), .addr_o(hst_addr_i),
    .wr_o(hst_wr_i), .rd_o(hst_rd_i), .wdata_o(hst_wdata_i), .rd_val_o(host_val),
    .rd_tick_o(host_tick));
  initial begin
    clk_sys_i = 1'b0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(string n, logic [79:0] seen, logic [79:0] expv);
    compares++;
    if (seen !== expv) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, expv, seen);
    end
  endtask : check
  task automatic pop_check(logic [79:0] seen);
    if (exp_q.size() == 0) check("queue", seen, 80'hx);
    else check(nam_q.pop_front(), seen, exp_q.pop_front());
  endtask : pop_check
  function automatic logic [1:0] aclass(logic [7:0] l);
    if (l >= 8'hc0) return 2'h3;
    if (l >= 8'h80) return 2'h2;
    return (l == 8'h00) ? 2'h0 : 2'h1;
  endfunction : aclass
  task automatic note(string n, logic [79:0] v);
    nam_q.push_back(n);
    exp_q.push_back(v);
  endtask : note
  task automatic rd_chk(logic [11:0] a, logic [7:0] v);
    note("rdata", {72'h0, v});
    u_host.rd(a);
  endtask : rd_chk
  task automatic run(logic [7:0] f, logic [7:0] sc, logic [7:0] op, logic good);
    int n;
    n = 0;
    note("state", {11'h0, m_en, m_en ? m_cnt : 8'h00, m_xfer, m_aam, aclass(m_aam.level),
                   ID_W47, m_en ? {ID_W59_HI, m_cnt} : ID_W59_OFF,
                   m_aam.en ? {1'b1, m_aam.level} : 9'h000});
    u_host.cmd(f, sc, 8'h00, op);
    while (hst_irq_o !== 1'b1 && n < 50) begin
      @(posedge clk_sys_i);
      n++;
    end
    check("irq", {79'h0, hst_irq_o}, 80'h1);
    rd_chk(OFS_CMD_STAT, good ? 8'h40 : 8'h41);
    rd_chk(OFS_FEAT_ERR, good ? 8'h00 : 8'h04);
  endtask : run
  task automatic close_out();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    forever begin
      @(posedge hst_irq_o);
      repeat (2) @(posedge clk_sys_i);
      #1 pop_check({11'h0, mult_en_o, mult_en_o ? mult_cnt_o : 8'h00, xfer_code_o, aam_o,
                    aam_class_o, ident_o.w47, ident_o.w59,
                    {ident_o.w86_b9, ident_o.w94_lo}});
    end
  end
  initial begin
    // skip the start-up settle of the tick
    wait (host_tick === 1'b0);
    forever begin
      @(host_tick);
      #1 pop_check({72'h0, host_val});
    end
  end
  initial begin
    #300000;
    failures++;
    $display("[ERR] watchdog expected done seen hang");
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    compares = 0;
    seed = 31964;
    sys_rst_i = 1'b1;
    hw_rst_n_i = 1'b1;
    sw_rst_i = 1'b0;
    lv = 8'h80 + 8'($random(seed) & 63);
    aam_nv_i = '{en: 1'b1, level: lv};
    m_aam = aam_nv_i;
    {m_en, m_cnt, m_xfer} = 17'h0;
    repeat (2) @(posedge clk_sys_i);
    #1 sys_rst_i = 1'b0;
    run(8'h04, 8'h00, OP_SET_FEAT, 1'b1);
    for (i = 0; i < 256; i++) begin
      c = 8'(i);
      ok = (c == 8'h00) || (c[7:3] == XT_PIO_FC && c[2:0] <= 3'h4) ||
           (c[7:3] == XT_MDMA && c[2:0] <= 3'h2) || (c[7:3] == XT_UDMA && c[2:0] <= 3'h5);
      if (ok) m_xfer = c;
      run(SUB_XFER, c, OP_SET_FEAT, ok);
    end
    for (i = 0; i < 12; i++) begin
      lv = (i < 8) ? 8'(64'hff_fe_c0_bf_80_7f_01_00 >> (8 * i)) : 8'($random(seed));
      ok = (lv != AAM_RSVD);
      if (ok) m_aam = '{en: 1'b1, level: lv};
      run(SUB_AAM_ON, lv, OP_SET_FEAT, ok);
    end
    m_aam.en = 1'b0;
    run(SUB_AAM_OFF, 8'h00, OP_SET_FEAT, 1'b1);
    m_aam = '{en: 1'b1, level: 8'hc0};
    run(SUB_AAM_ON, 8'hc0, OP_SET_FEAT, 1'b1);
    run(8'h01, 8'h00, OP_SET_FEAT, 1'b0);
    run(8'h10, 8'h00, OP_SET_FEAT, 1'b0);
    for (i = 0; i < 11; i++) begin
      c = (i < 10) ? 8'(80'hff_01_11_20_02_00_04_08_03_10 >> (8 * i)) :
          8'h02 << ($random(seed) & 3);
      ok = (c == 8'h00) || (c == 8'h02) || (c == 8'h04) || (c == 8'h08) || (c == 8'h10);
      m_en = ok && (c != 8'h00);
      if (m_en) m_cnt = c;
      run(8'h00, c, OP_SET_MULT, ok);
    end
    rd_chk(OFS_SECCNT, c);
    rd_chk(12'h1f0, 8'h00);
    // command for the other drive unit is ignored
    u_host.cmd(8'h00, 8'h00, 8'h10, OP_SET_MULT);
    repeat (20) @(posedge clk_sys_i);
    run(8'h04, 8'h00, OP_SET_FEAT, 1'b1);
    #1 sw_rst_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    #1 sw_rst_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    run(8'h04, 8'h00, OP_SET_FEAT, 1'b1);
    #1 hw_rst_n_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    #1 hw_rst_n_i = 1'b1;
    repeat (4) @(posedge clk_sys_i);
    m_en = 1'b0;
    m_xfer = XFER_RST;
    run(8'h04, 8'h00, OP_SET_FEAT, 1'b1);
    // power cycle with the saved acoustic state fed back
    #1 sys_rst_i = 1'b1;
    aam_nv_i = m_aam;
    repeat (2) @(posedge clk_sys_i);
    #1 sys_rst_i = 1'b0;
    run(8'h04, 8'h00, OP_SET_FEAT, 1'b1);
    close_out();
  end
endmodule : ata_feature_and_block_mode_setup_test
`default_nettype wire
